// ### hdl/sdr_pkg.sv
// Shared constants for the SDRAM device end and its controller end.
// Assumes one 100 MHz clock shared by both ends.
package sdr_pkg;
  localparam int BANKS  = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W  = 12;
  localparam int ADDR_W = 12;
  localparam int AP_BIT = 10;

  // Command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // Mode word carried on the address lines with the mode command
  localparam int MODE_W      = 7;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_LT_LSB = 4;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_2   = 3'h2;
  localparam logic [2:0] LAT_3   = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RST = 7'h30;

  // Timing
  localparam int CLK_MHZ    = 100;
  localparam int TRP_NS     = 20;
  localparam int TRP_CYC    = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_NS     = 15600;
  localparam int REF_AT_NS  = 3900;
  localparam int REF_CYC    = REF_NS * CLK_MHZ / 1000;
  localparam int REF_AT_CYC = REF_AT_NS * CLK_MHZ / 1000;

  // Controller register map (APB byte offsets)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;

  // Software opcodes in CMD[2:0]; CMD[3] is auto precharge / all banks
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_RD  = 3'h2;
  localparam logic [2:0] OP_WR  = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  localparam logic [2:0] OP_REF = 3'h5;
  localparam logic [2:0] OP_MRS = 3'h6;
  localparam logic [2:0] OP_BST = 3'h7;
  localparam int CMD_AP_BIT = 3;
  localparam int ADDR_BA_LSB = 12;
  localparam int CFG_REN_BIT = 0;
  localparam int CFG_LT_LSB  = 1;
  localparam logic [31:0] CFG_RST = 32'h00000007;
endpackage

// ### hdl/sdr_if.sv
// Pins between the memory controller end and the SDRAM device end.
// The data bus level is resolved here from the two output enables.
`timescale 1ns/100ps
interface sdr_if #(
  parameter int DQ_W = 4
) (
  input logic ref_clk,
  input logic reset
);
  logic                      cke;
  logic                      cs_n;
  logic                      ras_n;
  logic                      cas_n;
  logic                      we_n;
  logic                      bank_select_bit0;
  logic                      bank_select_bit1;
  logic [sdr_pkg::ADDR_W-1:0] row_column_address_lines;
  logic [DQ_W-1:0]           ctrl_dq_out;
  logic                      ctrl_dq_oe;
  logic [DQ_W-1:0]           mem_dq_out;
  logic                      mem_dq_oe;
  logic [DQ_W-1:0]           dq;

  // Undriven bus reads as zero; device drive takes precedence
  assign dq = mem_dq_oe ? mem_dq_out : (ctrl_dq_oe ? ctrl_dq_out : '0);

  modport mem (
    input  ref_clk, reset, cke, cs_n, ras_n, cas_n, we_n,
    input  bank_select_bit0, bank_select_bit1, row_column_address_lines,
    input  dq,
    output mem_dq_out, mem_dq_oe
  );
  modport ctrl (
    input  ref_clk, reset, dq,
    output cke, cs_n, ras_n, cas_n, we_n,
    output bank_select_bit0, bank_select_bit1, row_column_address_lines,
    output ctrl_dq_out, ctrl_dq_oe
  );
endinterface // sdr_if

// ### hdl/sdr_mem.sv
// SDRAM device end: four banks, row activation, bursts, auto precharge.
// Assumes the controller keeps refresh and opens rows before access.
`timescale 1ns/100ps
module sdr_mem #(
  parameter int DQ_W           = 4,
  parameter int STORE_ROW_BITS = 12
) (
  sdr_if.mem                       m,
  output logic                     powered_down,
  output logic [sdr_pkg::ROW_W-1:0] refresh_row
);
  import sdr_pkg::*;

  localparam int COL_W = (DQ_W == 4) ? 10 : ((DQ_W == 8) ? 9 : 8);
  localparam int MEM_AW = BANK_W + STORE_ROW_BITS + COL_W;
  localparam int PRE_W = 4;

  logic [DQ_W-1:0]   mem_r [0:(2**MEM_AW)-1];
  logic [MODE_W-1:0] mode_r;
  logic [BANKS-1:0]  open_r;
  logic [ROW_W-1:0]  row_r [BANKS];
  logic [PRE_W-1:0]  pre_r [BANKS];
  logic              bact_r;
  logic              bwr_r;
  logic              bap_r;
  logic [BANK_W-1:0] bbank_r;
  logic [ROW_W-1:0]  brow_r;
  logic [COL_W-1:0]  bstart_r;
  logic [COL_W-1:0]  bcnt_r;
  logic [DQ_W-1:0]   rd0_r;
  logic [DQ_W-1:0]   rd1_r;
  logic              rv0_r;
  logic              rv1_r;
  logic [DQ_W-1:0]   dq_out_r;
  logic              dq_oe_r;
  logic              pd_r;
  logic [ROW_W-1:0]  ref_row_r;

  logic [3:0]        cmd;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] a;
  logic              live;
  logic              is_rw;
  logic              bterm;
  logic [COL_W-1:0]  mask;
  logic              page;
  logic              last;
  logic              beat;
  logic              beat_wr;
  logic [BANK_W-1:0] beat_bank;
  logic [ROW_W-1:0]  beat_row;
  logic [COL_W-1:0]  beat_col;
  logic [MEM_AW-1:0] maddr;
  logic [BANKS-1:0]  ap_fire;
  logic              all_idle;

  assign cmd  = {m.cs_n, m.ras_n, m.cas_n, m.we_n};
  assign ba   = {m.bank_select_bit1, m.bank_select_bit0};
  assign a    = m.row_column_address_lines;
  assign live = m.cke;
  // accesses to a closed bank are dropped
  assign is_rw = live && (cmd == CMD_RD || cmd == CMD_WR) && open_r[ba];
  assign bterm = live && (cmd == CMD_BST);
  assign page  = (mode_r[MODE_BL_LSB +: 3] == BL_PAGE);

  // burst length as a column mask
  always_comb begin
    case (mode_r[MODE_BL_LSB +: 3])
      BL_1:    mask = '0;
      BL_2:    mask = COL_W'(1);
      BL_4:    mask = COL_W'(3);
      BL_8:    mask = COL_W'(7);
      BL_PAGE: mask = '1;
      default: mask = '0;
    endcase
  end

  assign last = (bcnt_r == mask) && !page;

  // a new read or write overrides the running burst
  always_comb begin
    beat      = 1'b0;
    beat_wr   = 1'b0;
    beat_bank = bbank_r;
    beat_row  = brow_r;
    beat_col  = '0;
    if (is_rw) begin
      beat      = 1'b1;
      beat_wr   = (cmd == CMD_WR);
      beat_bank = ba;
      beat_row  = row_r[ba];
      // start column from low address lines
      beat_col  = a[COL_W-1:0];
    end else if (bact_r && !bterm) begin
      beat      = 1'b1;
      beat_wr   = bwr_r;
      if (mode_r[MODE_BT_BIT] && !page)
        beat_col = (bstart_r & ~mask) | ((bstart_r ^ bcnt_r) & mask);
      else
        beat_col = (bstart_r & ~mask) | ((bstart_r + bcnt_r) & mask);
    end
  end

  assign maddr = {beat_bank, beat_row[STORE_ROW_BITS-1:0], beat_col};

  // auto precharge at burst end or when an access to another bank interrupts
  always_comb begin
    ap_fire = '0;
    if (is_rw && mask == '0 && a[AP_BIT])
      ap_fire[ba] = 1'b1;
    if (bact_r && bap_r && !is_rw && last)
      ap_fire[bbank_r] = 1'b1;
    if (bact_r && bap_r && is_rw && ba != bbank_r)
      ap_fire[bbank_r] = 1'b1;
  end

  always_comb begin
    all_idle = (open_r == '0);
    for (int b = 0; b < BANKS; b++) begin
      if (pre_r[b] != '0)
        all_idle = 1'b0;
    end
  end

  // everything below samples on the rising edge
  always_ff @(posedge m.ref_clk) begin
    if (m.reset) begin
      bact_r   <= 1'b0;
      bwr_r    <= 1'b0;
      bap_r    <= 1'b0;
      bbank_r  <= '0;
      brow_r   <= '0;
      bstart_r <= '0;
      bcnt_r   <= '0;
    end else if (is_rw) begin
      bact_r   <= (mask != '0);
      bwr_r    <= (cmd == CMD_WR);
      bap_r    <= a[AP_BIT];
      bbank_r  <= ba;
      brow_r   <= row_r[ba];
      bstart_r <= a[COL_W-1:0];
      bcnt_r   <= COL_W'(1);
    end else if (bact_r) begin
      if (bterm || last)
        bact_r <= 1'b0;
      bcnt_r <= bcnt_r + COL_W'(1);
    end
  end

  // each bank opens and precharges on its own
  always_ff @(posedge m.ref_clk) begin
    if (m.reset) begin
      open_r <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_r[b] <= '0;
        pre_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (pre_r[b] != '0)
          pre_r[b] <= pre_r[b] - PRE_W'(1);
        // bank and row captured on one edge
        if (live && cmd == CMD_ACT && ba == BANK_W'(b) && !open_r[b] &&
            pre_r[b] == '0) begin
          open_r[b] <= 1'b1;
          row_r[b]  <= a;
        end
        if (open_r[b] && (ap_fire[b] || (live && cmd == CMD_PRE &&
            (a[AP_BIT] || ba == BANK_W'(b))))) begin
          open_r[b] <= 1'b0;
          pre_r[b]  <= PRE_W'(TRP_CYC);
        end
      end
    end
  end

  always_ff @(posedge m.ref_clk) begin
    if (m.reset)
      mode_r <= MODE_RST;
    else if (live && cmd == CMD_MRS && all_idle)
      mode_r <= a[MODE_W-1:0];
  end

  // auto refresh walks an internal row counter
  always_ff @(posedge m.ref_clk) begin
    if (m.reset)
      ref_row_r <= '0;
    else if (live && cmd == CMD_REF && all_idle)
      ref_row_r <= ref_row_r + ROW_W'(1);
  end

  // power-down while clock enable is low and idle
  always_ff @(posedge m.ref_clk) begin
    if (m.reset)
      pd_r <= 1'b0;
    else
      pd_r <= !live && !bact_r;
  end

  // Storage holds no reset; contents are undefined until written
  always_ff @(posedge m.ref_clk) begin
    if (beat && beat_wr)
      mem_r[maddr] <= m.dq;
  end

  // Read pipe; a write beat flushes it to keep the bus free
  always_ff @(posedge m.ref_clk) begin
    if (m.reset || (beat && beat_wr)) begin
      rv0_r    <= 1'b0;
      rv1_r    <= 1'b0;
      dq_oe_r  <= 1'b0;
      rd0_r    <= '0;
      rd1_r    <= '0;
      dq_out_r <= '0;
    end else begin
      rv0_r <= beat;
      rd0_r <= beat ? mem_r[maddr] : '0;
      rv1_r <= rv0_r;
      rd1_r <= rd0_r;
      if (mode_r[MODE_LT_LSB +: 3] == LAT_2) begin
        dq_oe_r  <= rv0_r;
        dq_out_r <= rd0_r;
      end else begin
        dq_oe_r  <= rv1_r;
        dq_out_r <= rd1_r;
      end
    end
  end

  assign m.mem_dq_out  = dq_out_r;
  assign m.mem_dq_oe   = dq_oe_r;
  assign powered_down  = pd_r;
  assign refresh_row   = ref_row_r;
endmodule // sdr_mem

// ### hdl/sdr_ctrl.sv
// SDRAM controller end: APB registers, command issue and refresh timer.
// Assumes an APB master on the same clock as the memory pins.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module sdr_ctrl #(
  parameter int DQ_W    = 4,
  parameter int REF_INT = sdr_pkg::REF_CYC
) (
  sdr_if.ctrl          s,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import sdr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_RPRE  = 3'b100
  } sdr_st_e;

  sdr_st_e           st_r;
  logic              pready_r;
  logic [31:0]       prdata_r;
  logic              perr_r;
  logic [13:0]       addr_r;
  logic [DQ_W-1:0]   wdata_r;
  logic [DQ_W-1:0]   rdata_r;
  logic              rvalid_r;
  logic              refused_r;
  logic              ren_r;
  logic [2:0]        lat_r;
  logic              pend_r;
  logic [2:0]        pop_r;
  logic              pap_r;
  logic [BANKS-1:0]  open_r;
  logic [3:0]        cmd_r;
  logic [BANK_W-1:0] ba_r;
  logic [ADDR_W-1:0] a_r;
  logic              oe_r;
  logic [3:0]        rexp_r;
  logic [15:0]       rcnt_r;
  logic              rdue_r;
  logic [3:0]        wait_r;

  logic              acc;
  logic              hit;
  logic [BANK_W-1:0] pbank;
  logic              issue_rd;
  logic              go;
  logic              ok;
  logic [3:0]        pcmd;

  assign acc   = psel && penable && pready_r;
  assign hit   = (paddr == REG_CMD) || (paddr == REG_ADDR) ||
                 (paddr == REG_WDATA) || (paddr == REG_RDATA) ||
                 (paddr == REG_STATUS) || (paddr == REG_CONFIG);
  assign pbank = addr_r[ADDR_BA_LSB +: BANK_W];
  assign go    = (st_r == ST_IDLE) && pend_r && !(rdue_r && ren_r);
  // read/write only to a bank the controller opened
  assign ok    = !((pop_r == OP_RD || pop_r == OP_WR) && !open_r[pbank]);
  assign issue_rd = go && ok && (pop_r == OP_RD);

  always_comb begin
    case (pop_r)
      OP_ACT:  pcmd = CMD_ACT;
      OP_RD:   pcmd = CMD_RD;
      OP_WR:   pcmd = CMD_WR;
      OP_PRE:  pcmd = CMD_PRE;
      OP_REF:  pcmd = CMD_REF;
      OP_MRS:  pcmd = CMD_MRS;
      OP_BST:  pcmd = CMD_BST;
      default: pcmd = CMD_NOP;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge s.ref_clk) begin
    if (s.reset) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      perr_r   <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
      perr_r   <= psel && penable && !pready_r && !hit;
      prdata_r <= '0;
      if (psel && penable && !pready_r && !pwrite) begin
        case (paddr)
          REG_ADDR:   prdata_r <= 32'(addr_r);
          REG_WDATA:  prdata_r <= 32'(wdata_r);
          REG_RDATA:  prdata_r <= 32'(rdata_r);
          REG_STATUS: prdata_r <= 32'({open_r, rdue_r,
                                       pend_r || st_r != ST_IDLE,
                                       refused_r, rvalid_r});
          REG_CONFIG: prdata_r <= 32'({lat_r, ren_r});
          default:    prdata_r <= '0;
        endcase
      end
    end
  end

  // only latencies two and three are accepted
  always_ff @(posedge s.ref_clk) begin
    if (s.reset) begin
      addr_r  <= '0;
      wdata_r <= '0;
      ren_r   <= CFG_RST[CFG_REN_BIT];
      lat_r   <= CFG_RST[CFG_LT_LSB +: 3];
    end else if (acc && pwrite) begin
      if (paddr == REG_ADDR)
        addr_r <= pwdata[13:0];
      if (paddr == REG_WDATA)
        wdata_r <= pwdata[DQ_W-1:0];
      if (paddr == REG_CONFIG) begin
        ren_r <= pwdata[CFG_REN_BIT];
        lat_r <= (pwdata[CFG_LT_LSB +: 3] == LAT_2) ? LAT_2 : LAT_3;
      end
    end
  end

  // Pending command; a second write while pending is refused unless the pending one issues that cycle
  always_ff @(posedge s.ref_clk) begin
    if (s.reset) begin
      pend_r    <= 1'b0;
      pop_r     <= OP_NOP;
      pap_r     <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (acc && !pwrite && paddr == REG_STATUS)
        refused_r <= 1'b0;
      if (go)
        pend_r <= 1'b0;
      if (go && !ok)
        refused_r <= 1'b1;
      if (acc && pwrite && paddr == REG_CMD) begin
        if (pend_r && !go)
          refused_r <= 1'b1;
        else if (pwdata[2:0] != OP_NOP) begin
          pend_r <= 1'b1;
          pop_r  <= pwdata[2:0];
          pap_r  <= pwdata[CMD_AP_BIT];
        end
      end
    end
  end

  // refresh due flag; the set wins over the clear
  always_ff @(posedge s.ref_clk) begin
    if (s.reset) begin
      rcnt_r <= '0;
      rdue_r <= 1'b0;
    end else begin
      if (st_r == ST_RPRE && wait_r == '0)
        rdue_r <= 1'b0;
      if (rcnt_r == 16'(REF_INT - 1)) begin
        rcnt_r <= '0;
        rdue_r <= 1'b1;
      end else begin
        rcnt_r <= rcnt_r + 16'h0001;
      end
    end
  end

  // pins change only after rising edges
  always_ff @(posedge s.ref_clk) begin
    if (s.reset) begin
      st_r   <= ST_IDLE;
      cmd_r  <= CMD_NOP;
      ba_r   <= '0;
      a_r    <= '0;
      wait_r <= '0;
      open_r <= '0;
      oe_r   <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (rdue_r && ren_r) begin
            // Precharge all banks before the refresh
            cmd_r          <= CMD_PRE;
            a_r            <= '0;
            a_r[AP_BIT]    <= 1'b1;
            open_r         <= '0;
            wait_r         <= 4'(TRP_CYC);
            st_r           <= ST_RPRE;
          end else if (go && ok) begin
            cmd_r <= pcmd;
            ba_r  <= pbank;
            a_r   <= addr_r[ADDR_W-1:0];
            if (pop_r == OP_RD || pop_r == OP_WR || pop_r == OP_PRE)
              a_r[AP_BIT] <= pap_r;
            if (pop_r == OP_MRS)
              a_r[MODE_LT_LSB +: 3] <= lat_r;
            if (pop_r == OP_ACT)
              open_r[pbank] <= 1'b1;
            if (pop_r == OP_PRE && pap_r)
              open_r <= '0;
            if ((pop_r == OP_PRE && !pap_r) ||
                ((pop_r == OP_RD || pop_r == OP_WR) && pap_r))
              open_r[pbank] <= 1'b0;
            if (pop_r == OP_WR)
              oe_r <= 1'b1;
            if (pop_r == OP_RD)
              oe_r <= 1'b0;
            st_r <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          cmd_r <= CMD_NOP;
          st_r  <= ST_IDLE;
        end
        ST_RPRE: begin
          cmd_r <= CMD_NOP;
          if (wait_r == '0) begin
            cmd_r <= CMD_REF;
            st_r  <= ST_ISSUE;
          end else begin
            wait_r <= wait_r - 4'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Captures only the first beat of each read burst
  always_ff @(posedge s.ref_clk) begin
    if (s.reset) begin
      rexp_r   <= '0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rexp_r <= {rexp_r[2:0], issue_rd};
      if (acc && !pwrite && paddr == REG_RDATA)
        rvalid_r <= 1'b0;
      if (rexp_r[lat_r[1:0]]) begin
        rdata_r  <= s.dq;
        rvalid_r <= 1'b1;
      end
    end
  end

  assign s.cke              = !s.reset;
  assign {s.cs_n, s.ras_n, s.cas_n, s.we_n} = cmd_r;
  assign s.bank_select_bit0 = ba_r[0];
  assign s.bank_select_bit1 = ba_r[1];
  assign s.row_column_address_lines = a_r;
  assign s.ctrl_dq_out      = wdata_r;
  assign s.ctrl_dq_oe       = oe_r;
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = perr_r;
endmodule // sdr_ctrl

// ### testbench/sdr_sva.sv
// Pin checks on the link between the SDRAM controller and device ends.
// Assumes the signals of one sdr_if, one clock and a sync reset.
`timescale 1ns/100ps
module sdr_sva
  import sdr_pkg::*;
(
  input logic                    ref_clk,
  input logic                    reset,
  input logic                    cke,
  input logic                    cs_n,
  input logic                    ras_n,
  input logic                    cas_n,
  input logic                    we_n,
  input logic                    bank_select_bit0,
  input logic                    bank_select_bit1,
  input logic [ADDR_W-1:0]       row_column_address_lines,
  input logic                    ctrl_dq_oe,
  input logic                    mem_dq_oe
);
  logic [3:0] cmd;
  logic [1:0] ba;
  logic       a10;
  logic [3:0] open_r;
  logic [2:0] lat_r;

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign ba  = {bank_select_bit1, bank_select_bit0};
  assign a10 = row_column_address_lines[AP_BIT];

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Auto precharge counts as closing at issue, as the controller does
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      open_r <= 4'h0;
    end else if (cke) begin
      case (cmd)
        CMD_ACT: open_r[ba] <= 1'b1;
        CMD_PRE: open_r <= a10 ? 4'h0 : open_r & ~(4'h1 << ba);
        CMD_RD, CMD_WR: if (a10) open_r[ba] <= 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lat_r <= LAT_3;
    end else if (cke && cmd == CMD_MRS) begin
      lat_r <= row_column_address_lines[MODE_LT_LSB +: 3];
    end
  end

  property p_cke_up;
    cke;
  endproperty
  a_cke_up: assert property (p_cke_up)
    else $error("clock enable low out of reset");

  property p_cmd_gap;
    cmd != CMD_NOP |=> cmd == CMD_NOP;
  endproperty
  a_cmd_gap: assert property (p_cmd_gap)
    else $error("command held or repeated next cycle");

  property p_addr_hold;
    cmd == CMD_NOP |-> $stable({ba, row_column_address_lines});
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("bank or address moved without a command");

  property p_open_bank;
    (cmd == CMD_RD || cmd == CMD_WR) |-> open_r[ba];
  endproperty
  a_open_bank: assert property (p_open_bank)
    else $error("column access to a bank with no open row");

  property p_ref_closed;
    cmd == CMD_REF |-> open_r == 4'h0;
  endproperty
  a_ref_closed: assert property (p_ref_closed)
    else $error("refresh issued with a bank open");

  property p_wr_drive;
    cmd == CMD_WR |-> ctrl_dq_oe && !mem_dq_oe;
  endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("write data not driven at the write edge");

  property p_lat3;
    cmd == CMD_RD && lat_r == LAT_3 |-> ##3 mem_dq_oe;
  endproperty
  a_lat3: assert property (p_lat3)
    else $error("read data late at latency three");

  property p_lat2;
    cmd == CMD_RD && lat_r == LAT_2 |-> !mem_dq_oe ##2 mem_dq_oe;
  endproperty
  a_lat2: assert property (p_lat2)
    else $error("read data mistimed at latency two");
endmodule // sdr_sva

// ### testbench/sdram_bank_row_column_access_tb.sv
// Bench: APB master on the controller, device end on the far side.
// Assumes the sdr_pkg register map and a 100 MHz clock.
`timescale 1ns/100ps
module sdram_bank_row_column_access_tb;
  import sdr_pkg::*;
  localparam int REF_T = 40;
  logic             ref_clk;
  logic             reset;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             pd;
  logic [ROW_W-1:0] refresh_row;
  logic [31:0]      rdat;
  logic             rerr;
  logic [3:0]       beats[$];
  int               ref_cyc[$];
  int               ref_row[$];
  int               cyc = 0;
  int               failures = 0;
  int               num_checks = 0;

  sdr_if #(.DQ_W(4)) sdr_if_i (.ref_clk(ref_clk), .reset(reset));
  sdr_mem #(.DQ_W(4), .STORE_ROW_BITS(4)) sdr_mem_i (.m(sdr_if_i.mem),
    .powered_down(pd), .refresh_row(refresh_row));
  sdr_ctrl #(.DQ_W(4), .REF_INT(REF_T)) sdr_ctrl_i (.s(sdr_if_i.ctrl),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  sdr_sva sdr_sva_i (.ref_clk(ref_clk), .reset(reset),
    .cke(sdr_if_i.cke), .cs_n(sdr_if_i.cs_n), .ras_n(sdr_if_i.ras_n),
    .cas_n(sdr_if_i.cas_n), .we_n(sdr_if_i.we_n),
    .bank_select_bit0(sdr_if_i.bank_select_bit0),
    .bank_select_bit1(sdr_if_i.bank_select_bit1),
    .row_column_address_lines(sdr_if_i.row_column_address_lines),
    .ctrl_dq_oe(sdr_if_i.ctrl_dq_oe), .mem_dq_oe(sdr_if_i.mem_dq_oe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Wire monitor: read beats and refresh commands as the device sees them
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sdr_if_i.mem_dq_oe === 1'b1) beats.push_back(sdr_if_i.dq);
    if ({sdr_if_i.cs_n, sdr_if_i.ras_n, sdr_if_i.cas_n,
         sdr_if_i.we_n} === CMD_REF) begin
      ref_cyc.push_back(cyc);
      ref_row.push_back(int'(refresh_row));
    end
  end

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    failures++;
    complete_run();
  endtask

  // One idle cycle after each transfer keeps drives one per time step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  // Pins show the command one edge after the write, device acts one later
  task automatic cmd(input logic [3:0] op, input logic [1:0] b,
                     input logic [11:0] a);
    apb(1'b1, REG_ADDR, {18'h0, b, a});
    apb(1'b1, REG_CMD, {28'h0, op});
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic wait_rvalid();
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b1 && n < 30);
    if (rdat[0] !== 1'b1) hang();
  endtask

  task automatic wait_q(input int cnt);
    int n;
    for (n = 0; n < 40 && beats.size() < cnt; n++) @(negedge ref_clk);
    if (beats.size() < cnt) hang();
  endtask

  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    reset <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk(REG_CONFIG, CFG_RST);
    rd_chk(REG_CMD, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, rerr}, 32'h1);
    check(rdat, 32'h0);
    apb(1'b1, REG_CONFIG, 32'h8);
    rd_chk(REG_CONFIG, 32'h6);
    check({31'h0, pd}, 32'h0);
    $display("test registers done");
    cmd({1'b0, OP_MRS}, 2'h0, 12'h030);
    cmd({1'b0, OP_ACT}, 2'h1, 12'h005);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, REG_WDATA, 32'(i + 1));
      cmd({1'b0, OP_WR}, 2'h1, 12'(i));
    end
    // Sequential then interleaved order, four beats from column one
    for (int t = 0; t < 2; t++) begin
      cmd({1'b1, OP_PRE}, 2'h0, 12'h000);
      cmd({1'b0, OP_MRS}, 2'h0, t ? 12'h03A : 12'h032);
      cmd({1'b0, OP_ACT}, 2'h1, 12'h005);
      beats.delete();
      cmd({1'b0, OP_RD}, 2'h1, 12'h001);
      wait_q(4);
      for (int k = 0; k < 4; k++)
        check(32'(beats[k]), t ? 32'((1 ^ k) + 1) : 32'((1 + k) % 4 + 1));
      wait_rvalid();
      rd_chk(REG_RDATA, 32'h2);
    end
    $display("test bursts done");
    cmd({1'b1, OP_RD}, 2'h1, 12'h002);
    wait_rvalid();
    rd_chk(REG_RDATA, 32'h3);
    cmd({1'b0, OP_RD}, 2'h1, 12'h002);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rdat[1]}, 32'h1);
    $display("test auto precharge done");
    // No precharge here: the mode load only lands if the bank closed itself
    apb(1'b1, REG_CONFIG, 32'h4);
    cmd({1'b0, OP_MRS}, 2'h0, 12'h000);
    cmd({1'b0, OP_ACT}, 2'h1, 12'h005);
    cmd({1'b0, OP_RD}, 2'h1, 12'h003);
    wait_rvalid();
    rd_chk(REG_RDATA, 32'h4);
    $display("test latency two done");
    // Page burst cut by terminate; it lands eleven edges after the read
    cmd({1'b1, OP_PRE}, 2'h0, 12'h000);
    cmd({1'b0, OP_MRS}, 2'h0, 12'h007);
    cmd({1'b0, OP_ACT}, 2'h1, 12'h005);
    beats.delete();
    cmd({1'b0, OP_RD}, 2'h1, 12'h000);
    cmd({1'b0, OP_BST}, 2'h1, 12'h000);
    check(32'(beats.size()), 32'hB);
    $display("test burst terminate done");
    ref_cyc.delete();
    ref_row.delete();
    apb(1'b1, REG_CONFIG, 32'h7);
    // The first gap may be short if a stale due flag meets a new one
    for (int n = 0; n < 200 && ref_cyc.size() < 4; n++) @(negedge ref_clk);
    if (ref_cyc.size() < 4) hang();
    check(32'(ref_cyc[3] - ref_cyc[2]), 32'(REF_T));
    check(32'(ref_row[3] - ref_row[2]), 32'h1);
    $display("test refresh done");
    complete_run();
  end
endmodule // sdram_bank_row_column_access_tb
